// [rtl/wp_ctrl.sv]
// Write-protect control for two peripheral groups behind AXI4-Lite
// ==========================================================
// What this block does
// - Writing one to a bit of a clear register unprotects it.
// - Zero bits written to either register change nothing.
// - Each bit reads 0 when writable and 1 when protected.
// - Group A: 6 ext int, 5 RTC, 4 watchdog, 3 clock, 2 sysctl, 1 power.
// - Group B bits: 6 trace, 3 port, 2 flash, 1 debug, all read/write.
// - Each group has a set register at offset 0x04 with the same bit map.
// - Group A resets to all zeros.
// - Group B resets with only the debug bit set.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "wp_ctrl_cfg.svh"
module wp_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // AXI4-Lite write address
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Protect state per peripheral
  output logic ext_interrupt_unit_bit,
  output logic rtc_bit,
  output logic watchdog_bit,
  output logic clock_generator_bit,
  output logic system_control_bit,
  output logic power_manager_bit,
  output logic trace_buffer_bit,
  output logic io_port_bit,
  output logic flash_controller_bit,
  output logic debug_unit_bit
);
  // ==========================================================
  // Address decode
  function automatic logic [2:0] decode(input logic [4:0] a);
    // {valid, group B, set}
    case (a)
      `WP_GRP_A_BASE + `WP_CLR_OFS: decode = 3'h4;
      `WP_GRP_A_BASE + `WP_SET_OFS: decode = 3'h5;
      `WP_GRP_B_BASE + `WP_CLR_OFS: decode = 3'h6;
      `WP_GRP_B_BASE + `WP_SET_OFS: decode = 3'h7;
      default: decode = 3'h0;
    endcase
  endfunction

  // ==========================================================
  // Write channel
  logic awHeld_q, wHeld_q;
  logic [4:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  logic [2:0] wDec;
  wp_ctrl_pkg::wp_op_t opA, opB, opSel;
  logic [31:0] stateA, stateB;

  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wDec = decode(awAddr_q);
  assign opSel = wDec[0] ? wp_ctrl_pkg::OP_SET : wp_ctrl_pkg::OP_CLEAR;
  assign opA = (doWrite && wDec[2] && !wDec[1]) ? opSel
               : wp_ctrl_pkg::OP_NONE;
  assign opB = (doWrite && wDec[2] && wDec[1]) ? opSel
               : wp_ctrl_pkg::OP_NONE;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 5'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      if (doWrite) begin
        awHeld_q <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (s_axi_awvalid && !awHeld_q) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wHeld_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= 1'b0;
      if (doWrite) begin
        wHeld_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (s_axi_wvalid && !wHeld_q) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WP_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wDec[2] ? `WP_RESP_OKAY : `WP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Protect groups
  wp_group #(
    .MASK(`WP_A_MASK),
    .RESETVAL(`WP_A_RESET)
  ) u_group_a (
    .core_clk(core_clk),
    .rstn(rstn),
    .op(opA),
    .wdata(wData_q),
    .wstrb(wStrb_q),
    .state(stateA)
  );
  wp_group #(
    .MASK(`WP_B_MASK),
    .RESETVAL(`WP_B_RESET)
  ) u_group_b (
    .core_clk(core_clk),
    .rstn(rstn),
    .op(opB),
    .wdata(wData_q),
    .wstrb(wStrb_q),
    .state(stateB)
  );

  // ==========================================================
  // Read channel
  logic [2:0] rDec;
  assign rDec = decode(s_axi_araddr);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `WP_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        if (!rDec[2]) begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `WP_RESP_SLVERR;
        end else begin
          s_axi_rdata <= rDec[1] ? stateB : stateA;
          s_axi_rresp <= `WP_RESP_OKAY;
        end
      end else if (s_axi_arvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Protect state outputs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ext_interrupt_unit_bit <= 1'b0;
      rtc_bit <= 1'b0;
      watchdog_bit <= 1'b0;
      clock_generator_bit <= 1'b0;
      system_control_bit <= 1'b0;
      power_manager_bit <= 1'b0;
      trace_buffer_bit <= 1'b0;
      io_port_bit <= 1'b0;
      flash_controller_bit <= 1'b0;
      debug_unit_bit <= 1'b1;
    end else begin
      ext_interrupt_unit_bit <= stateA[`WP_A_EXT_INT_BIT];
      rtc_bit <= stateA[`WP_A_RTC_BIT];
      watchdog_bit <= stateA[`WP_A_WATCHDOG_BIT];
      clock_generator_bit <= stateA[`WP_A_CLKGEN_BIT];
      system_control_bit <= stateA[`WP_A_SYSCTL_BIT];
      power_manager_bit <= stateA[`WP_A_POWER_BIT];
      trace_buffer_bit <= stateB[`WP_B_TRACE_BIT];
      io_port_bit <= stateB[`WP_B_PORT_BIT];
      flash_controller_bit <= stateB[`WP_B_FLASH_BIT];
      debug_unit_bit <= stateB[`WP_B_DEBUG_BIT];
    end
  end

  // ==========================================================
  // Checks
  AST_CLEAR_WORKS: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (opA == wp_ctrl_pkg::OP_CLEAR && wStrb_q[0] && wData_q[6])
    |=> !stateA[6])
    else $error("clear write left bit protected");
  AST_ZERO_NOCHANGE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (opB != wp_ctrl_pkg::OP_NONE && !wData_q[1])
    |=> stateB[1] == $past(stateB[1]))
    else $error("zero write changed state");
  AST_READ_STATE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (s_axi_arvalid && s_axi_arready && !s_axi_rvalid
     && s_axi_araddr == 5'h10 && opB == wp_ctrl_pkg::OP_NONE)
    |=> s_axi_rvalid && s_axi_rdata == stateB)
    else $error("read data differs from state");
  AST_A_MAP: assert property (
    @(posedge core_clk) disable iff (!rstn)
    ##1 watchdog_bit == $past(stateA[4]))
    else $error("watchdog bit mismatch");
  AST_B_MAP: assert property (
    @(posedge core_clk) disable iff (!rstn)
    ##1 flash_controller_bit == $past(stateB[2]))
    else $error("flash bit mismatch");
  AST_SET_WORKS: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (opB == wp_ctrl_pkg::OP_SET && wStrb_q[0] && wData_q[3])
    |=> stateB[3] ##1 io_port_bit)
    else $error("set write did not protect port");
  AST_A_RESET: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !$past(rstn) |-> stateA == `WP_A_RESET && !power_manager_bit)
    else $error("group A state wrong after reset");
  AST_B_RESET: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !$past(rstn) |-> stateB == `WP_B_RESET && debug_unit_bit)
    else $error("group B state wrong after reset");
  AST_SET_PROTECT: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (opA == wp_ctrl_pkg::OP_SET && wStrb_q[0] && wData_q[1])
    |=> stateA[1])
    else $error("set write did not protect");
  AST_BRESP: assert property (
    @(posedge core_clk) disable iff (!rstn)
    doWrite |=> s_axi_bvalid && s_axi_bresp ==
      ($past(awAddr_q[3] || awAddr_q[1:0] != 2'h0)
       ? `WP_RESP_SLVERR : `WP_RESP_OKAY))
    else $error("write response wrong");
  AST_RDATA_UNUSED: assert property (
    @(posedge core_clk) disable iff (!rstn)
    s_axi_rvalid |-> (s_axi_rdata & ~(`WP_A_MASK | `WP_B_MASK)) == 32'h0)
    else $error("undefined bit read as one");
endmodule // wp_ctrl

// [rtl/wp_ctrl_cfg.svh]
// Offsets, bit positions and reset values of the write-protect control
`ifndef WP_CTRL_CFG_SVH
`define WP_CTRL_CFG_SVH
// ==========================================================
// Register map (byte addresses)
`define WP_GRP_A_BASE 5'h00
`define WP_GRP_B_BASE 5'h10
`define WP_CLR_OFS 5'h00
`define WP_SET_OFS 5'h04
// ==========================================================
// Group A bit positions
`define WP_A_EXT_INT_BIT 6
`define WP_A_RTC_BIT 5
`define WP_A_WATCHDOG_BIT 4
`define WP_A_CLKGEN_BIT 3
`define WP_A_SYSCTL_BIT 2
`define WP_A_POWER_BIT 1
// Group B bit positions
`define WP_B_TRACE_BIT 6
`define WP_B_PORT_BIT 3
`define WP_B_FLASH_BIT 2
`define WP_B_DEBUG_BIT 1
// ==========================================================
// Implemented bits and reset values
`define WP_A_MASK 32'h0000007E
`define WP_B_MASK 32'h0000004E
`define WP_A_RESET 32'h00000000
`define WP_B_RESET 32'h00000002
// ==========================================================
// Bus answers
`define WP_RESP_OKAY 2'h0
`define WP_RESP_SLVERR 2'h2
`endif

// [rtl/wp_ctrl_pkg.sv]
// Types shared by the write-protect control files
package wp_ctrl_pkg;
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_CLEAR = 2'h1,
    OP_SET = 2'h3
  } wp_op_t;
  typedef logic [31:0] wp_word_t;
endpackage

// [rtl/wp_group.sv]
// One group of protect-state bits with clear and set updates
`timescale 1ns/1ps
module wp_group #(
  parameter logic [31:0] MASK = 32'h00000000,
  parameter logic [31:0] RESETVAL = 32'h00000000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Update request
  input wire wp_ctrl_pkg::wp_op_t op,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Protect state
  output logic [31:0] state
);
  logic [31:0] stateQ;
  logic [31:0] laneMask;
  logic [31:0] hit;

  // ==========================================================
  // Byte lanes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign laneMask[gi*8 +: 8] = {8{wstrb[gi]}};
    end
  endgenerate
  // Only ones in strobed lanes at implemented bits act
  assign hit = wdata & laneMask & MASK;

  // ==========================================================
  // State
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stateQ <= RESETVAL;
    end else begin
      if (op == wp_ctrl_pkg::OP_CLEAR) begin
        stateQ <= stateQ & ~hit;
      end else if (op == wp_ctrl_pkg::OP_SET) begin
        stateQ <= (stateQ | hit) & MASK;
      end
    end
  end
  assign state = stateQ & MASK;
endmodule // wp_group

// [sim/test_peripheral_write_protect_ctrl.sv]
// Self-checking bench for the write-protect control
`timescale 1ns/1ps
`include "wp_ctrl_cfg.svh"
module test_peripheral_write_protect_ctrl;
  // ==========================================================
  // Signals
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] awAddr = 5'h00, arAddr = 5'h00;
  logic [31:0] wData = 32'h00000000;
  logic [3:0] wStrb = 4'hF;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic extIntBit, rtcBit, wdogBit, clkGenBit, sysCtlBit, pwrBit;
  logic traceBit, portBit, flashBit, debugBit;
  logic [31:0] outA, outB;
  int miscompares = 0;
  int cmpCount = 0;
  int cycles = 0;
  assign outA = {25'h0000000, extIntBit, rtcBit, wdogBit, clkGenBit,
    sysCtlBit, pwrBit, 1'b0};
  assign outB = {25'h0000000, traceBit, 2'h0, portBit, flashBit,
    debugBit, 1'b0};
  // ==========================================================
  // Design
  wp_ctrl u_wp_ctrl (.core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .ext_interrupt_unit_bit(extIntBit),
    .rtc_bit(rtcBit), .watchdog_bit(wdogBit),
    .clock_generator_bit(clkGenBit), .system_control_bit(sysCtlBit),
    .power_manager_bit(pwrBit), .trace_buffer_bit(traceBit),
    .io_port_bit(portBit), .flash_controller_bit(flashBit),
    .debug_unit_bit(debugBit));
  // ==========================================================
  // Clock and timeout
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end
  // ==========================================================
  // Helpers
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    cmpCount = cmpCount + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic axiWrite(input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] expResp);
    logic aw, w, b;
    logic [1:0] resp;
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge core_clk);
      aw = awValid && (awReady === 1'b1);
      w = wValid && (wReady === 1'b1);
      b = (bValid === 1'b1);
      resp = bResp;
      @(posedge core_clk);
      if (aw) awValid <= 1'b0;
      if (w) wValid <= 1'b0;
      if (b) bReady <= 1'b0;
    end
    @(posedge core_clk);
    check("bresp", {30'h00000000, resp}, {30'h00000000, expResp});
  endtask
  task automatic readCheck(input logic [4:0] a, input logic [31:0] exp,
    input logic [1:0] expResp);
    logic ar, r;
    logic [31:0] d;
    logic [1:0] resp;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge core_clk);
      ar = arValid && (arReady === 1'b1);
      r = (rValid === 1'b1);
      d = rData;
      resp = rResp;
      @(posedge core_clk);
      if (ar) arValid <= 1'b0;
      if (r) rReady <= 1'b0;
    end
    @(posedge core_clk);
    check("rdata", d, exp);
    check("rresp", {30'h00000000, resp}, {30'h00000000, expResp});
  endtask
  task automatic checkOut(input logic [31:0] expA, input logic [31:0] expB);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check("group A outputs", outA, expA);
    check("group B outputs", outB, expB);
    @(posedge core_clk);
  endtask
  task automatic applyReset();
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic testReset();
    checkOut(32'h00000000, 32'h00000002);
    readCheck(5'h00, 32'h00000000, `WP_RESP_OKAY);
    readCheck(5'h04, 32'h00000000, `WP_RESP_OKAY);
    readCheck(5'h10, 32'h00000002, `WP_RESP_OKAY);
    readCheck(5'h14, 32'h00000002, `WP_RESP_OKAY);
  endtask
  task automatic testSetA();
    axiWrite(5'h04, 32'hFFFFFFFF, 4'hF, `WP_RESP_OKAY);
    readCheck(5'h00, 32'h0000007E, `WP_RESP_OKAY);
    checkOut(32'h0000007E, 32'h00000002);
    axiWrite(5'h04, 32'h00000000, 4'hF, `WP_RESP_OKAY);
    readCheck(5'h04, 32'h0000007E, `WP_RESP_OKAY);
  endtask
  task automatic testClearA();
    axiWrite(5'h00, 32'h00000028, 4'hF, `WP_RESP_OKAY);
    readCheck(5'h04, 32'h00000056, `WP_RESP_OKAY);
    checkOut(32'h00000056, 32'h00000002);
    axiWrite(5'h00, 32'h0000007E, 4'hE, `WP_RESP_OKAY);
    readCheck(5'h00, 32'h00000056, `WP_RESP_OKAY);
  endtask
  task automatic testGroupB();
    axiWrite(5'h14, 32'hFFFFFFFF, 4'hF, `WP_RESP_OKAY);
    readCheck(5'h10, 32'h0000004E, `WP_RESP_OKAY);
    axiWrite(5'h10, 32'h00000042, 4'hF, `WP_RESP_OKAY);
    axiWrite(5'h14, 32'h00000000, 4'hF, `WP_RESP_OKAY);
    readCheck(5'h14, 32'h0000000C, `WP_RESP_OKAY);
    checkOut(32'h00000056, 32'h0000000C);
  endtask
  task automatic testUnmapped();
    axiWrite(5'h08, 32'hFFFFFFFF, 4'hF, `WP_RESP_SLVERR);
    readCheck(5'h0C, 32'h00000000, `WP_RESP_SLVERR);
    checkOut(32'h00000056, 32'h0000000C);
    axiWrite(5'h00, 32'h00000040, 4'h1, `WP_RESP_OKAY);
    readCheck(5'h00, 32'h00000016, `WP_RESP_OKAY);
    applyReset();
    checkOut(32'h00000000, 32'h00000002);
    readCheck(5'h10, 32'h00000002, `WP_RESP_OKAY);
  endtask
  // ==========================================================
  // Main sequence and verdict
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    testReset();
    testSetA();
    testClearA();
    testGroupB();
    testUnmapped();
    end_of_test();
  end
endmodule // test_peripheral_write_protect_ctrl
